// ===== shared/fan_pkg.sv
// Shared constants, types and duty mapping for the fan PWM controller.
package fan_pkg;

	// System clock and the slow time base that paces sequencing and PWM.
	localparam int CLK_HZ          = 20_000_000;
	localparam int TIMEBASE_HZ     = 30;
	localparam int TIMEBASE_CYCLES = CLK_HZ / TIMEBASE_HZ;
	localparam int STARTUP_PERIODS = 64;

	// Control levels in thousandths of supply; 1000 is full supply.
	localparam int LVL_W = 10;
	localparam int FRAC_W = 9;
	localparam logic [LVL_W-1:0]  FULL_DUTY_LEVEL = 10'h2BC;
	localparam logic [LVL_W-1:0]  DUTY_SPAN       = 10'h190;
	localparam logic [LVL_W-1:0]  ZERO_DUTY_LEVEL = FULL_DUTY_LEVEL - DUTY_SPAN;
	// Fault comparator sits above full duty; kept here for reference by users.
	localparam logic [LVL_W-1:0]  FAULT_LEVEL     = 10'h302;
	localparam logic [FRAC_W-1:0] FULL_FRAC       = 9'h190;
	localparam int STARTUP_CNT_W = 6;
	localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST = 6'h3F;

	typedef logic [LVL_W-1:0]  level_t;
	typedef logic [FRAC_W-1:0] frac_t;

	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_STARTUP  = 2'b01,
		ST_RUN      = 2'b10,
		ST_SLEEP    = 2'b11
	} fan_state_t;

	// Digital comparator results from the analog front end.
	typedef struct packed {
		logic pri_above_restart;
		logic pri_above_fault;
		logic pri_above_full;
		logic pri_below_sleep;
		logic sec_below_sleep;
		logic pri_above_resume;
		logic sec_above_resume;
		logic sleep_grounded;
	} cmp_t;

	// Maps the larger of two levels onto duty steps, 0 to DUTY_SPAN.
	function automatic frac_t level_to_frac(level_t a, level_t b);
		level_t m;
		m = (a > b) ? a : b;
		if (m >= FULL_DUTY_LEVEL) begin
			return FULL_FRAC;
		end else if (m <= ZERO_DUTY_LEVEL) begin
			return '0;
		end else begin
			return frac_t'(m - ZERO_DUTY_LEVEL);
		end
	endfunction

endpackage

// ===== rtl/timebase_gen.sv
// Slow time base: period counter with a pulse on the last cycle of each period.
`timescale 1ns/10ps
module timebase_gen #(
	parameter int PERIOD = fan_pkg::TIMEBASE_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        shutdown,
	output logic [31:0]      phase,
	output logic             tick
);
	import fan_pkg::*;

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	always_comb begin
		tick  = (cnt_q == 32'(PERIOD - 1));
		cnt_d = tick ? 32'h0 : cnt_q + 32'h1;
	end

	always_ff @(posedge sys_clk or posedge shutdown) begin
		if (shutdown) begin
			cnt_q <= 32'h0;
		end else if (!nrst) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign phase = cnt_q;

endmodule

// ===== rtl/duty_map.sv
// Duty value taken once per period from the larger control level.
`timescale 1ns/10ps
module duty_map (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             shutdown,
	input  wire logic             tick,
	input  wire fan_pkg::level_t  pri_level,
	input  wire fan_pkg::level_t  sec_level,
	output fan_pkg::frac_t        duty_frac
);
	import fan_pkg::*;

	frac_t duty_q;
	frac_t duty_d;

	always_comb begin
		duty_d = tick ? level_to_frac(pri_level, sec_level) : duty_q;
	end

	always_ff @(posedge sys_clk or posedge shutdown) begin
		if (shutdown) begin
			duty_q <= '0;
		end else if (!nrst) begin
			duty_q <= '0;
		end else begin
			duty_q <= duty_d;
		end
	end

	assign duty_frac = duty_q;

endmodule

// ===== rtl/fan_pwm_ctrl.sv
// Fan PWM sequencer: startup kick, sleep, overtemperature flag and shutdown.
// Notes on behaviour
// [RULE_01] Duty follows whichever control input is higher.
// [RULE_02] Linear duty: full at 70 percent, span 40.
// [RULE_03] Primary above full level forces full duty.
// [RULE_04] Waking from sleep forces 64 periods high.
// [RULE_05] Power-on forces 64 periods high before control.
// [RULE_06] Both inputs below sleep level enter sleep.
// [RULE_07] Either input above resume level wakes, then startup.
// [RULE_08] One input below sleep level keeps running.
// [RULE_09] Primary above fault level asserts fault, full duty. The code flags it in ST_RUN only; the flag stays inactive during startup.
// [RULE_10] Fault releases itself when primary drops back.
// [RULE_11] Fault level always lies above full duty.
// [RULE_12] Primary below shutdown level stops everything.
// [RULE_13] One time base paces sequencing and PWM.
// [RULE_14] Primary above restart level resets like power-up.
// [RULE_15] Shutdown keeps drive off, fault flag inactive.
// [RULE_16] Sleep floats drive, fault flag inactive.
// [RULE_17] Grounded sleep threshold disables sleep entirely.
// [RULE_18] Comparators are inputs; shutdown resets asynchronously.
// [RULE_19] Counter over one period compared against duty.
`timescale 1ns/10ps
module fan_pwm_ctrl #(
	parameter int PERIOD_CYCLES = fan_pkg::TIMEBASE_CYCLES
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             primary_below_shutdown,
	input  wire fan_pkg::cmp_t    cmp,
	input  wire fan_pkg::level_t  primary_temp_input,
	input  wire fan_pkg::level_t  secondary_control_input,
	output logic                  fan_drive,
	output logic                  fan_drive_oe,
	output logic                  overtemp_fault_n,
	output logic                  overtemp_fault_oe
);
	import fan_pkg::*;

	logic [31:0] phase;
	logic        tick;
	frac_t       duty_frac;
	logic        pwm_on;

	fan_state_t               state_q;
	fan_state_t               state_d;
	cmp_t                     flg_q;
	cmp_t                     flg_d;
	logic [STARTUP_CNT_W-1:0] start_cnt_q;
	logic [STARTUP_CNT_W-1:0] start_cnt_d;
	logic                     drive_q;
	logic                     drive_d;
	logic                     drive_oe_q;
	logic                     drive_oe_d;
	logic                     fault_n_q;
	logic                     fault_n_d;
	logic                     both_below;
	logic                     wake;

	// The same period counter sets the PWM period and paces the sequencer.
	timebase_gen #(
		.PERIOD (PERIOD_CYCLES)
	) u_timebase (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.shutdown (primary_below_shutdown),
		.phase    (phase),
		.tick     (tick)
	); // see [RULE_13]

	duty_map u_duty (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.shutdown  (primary_below_shutdown),
		.tick      (tick),
		.pri_level (primary_temp_input),
		.sec_level (secondary_control_input),
		.duty_frac (duty_frac)
	); // see [RULE_01] see [RULE_02]

	// High while phase/period is below duty/span; widened to avoid overflow.
	always_comb begin
		pwm_on = (64'(phase) * 64'(DUTY_SPAN)) < (64'(duty_frac) * 64'(PERIOD_CYCLES)); // see [RULE_19]
	end

	always_comb begin
		both_below = flg_d.pri_below_sleep && flg_d.sec_below_sleep
			&& !flg_d.sleep_grounded; // see [RULE_08] see [RULE_17]
		wake = flg_d.pri_above_resume || flg_d.sec_above_resume;
	end

	// Comparator results are taken once per time-base period.
	always_comb begin
		flg_d = tick ? cmp : flg_q; // see [RULE_18]
	end

	always_comb begin
		state_d     = state_q;
		start_cnt_d = start_cnt_q;
		if (tick) begin
			unique case (state_q)
				ST_SHUTDOWN: begin
					if (flg_d.pri_above_restart) begin
						state_d     = ST_STARTUP; // see [RULE_14]
						start_cnt_d = '0;
					end
				end
				ST_STARTUP: begin
					if (start_cnt_q == STARTUP_LAST) begin
						state_d = ST_RUN; // see [RULE_04] see [RULE_05]
					end else begin
						start_cnt_d = start_cnt_q + 1'b1;
					end
				end
				ST_RUN: begin
					if (both_below) begin
						state_d = ST_SLEEP; // see [RULE_06]
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						state_d     = ST_STARTUP; // see [RULE_07]
						start_cnt_d = '0;
					end
				end
			endcase
		end
	end

	// Outputs are derived from next-state values so they change with the state.
	always_comb begin
		drive_d    = 1'b0;
		drive_oe_d = 1'b1;
		fault_n_d  = 1'b1;
		unique case (state_d)
			ST_SHUTDOWN: begin
				drive_oe_d = 1'b0; // see [RULE_15]
			end
			ST_STARTUP: begin
				drive_d = 1'b1; // see [RULE_04] see [RULE_05]
			end
			ST_RUN: begin
				// Fault level sits above full duty, so a fault also forces full duty.
				drive_d   = flg_d.pri_above_full || flg_d.pri_above_fault
					|| pwm_on; // see [RULE_03] see [RULE_11]
				fault_n_d = !flg_d.pri_above_fault; // see [RULE_09] see [RULE_10]
			end
			ST_SLEEP: begin
				drive_oe_d = 1'b0; // see [RULE_16]
			end
		endcase
	end

	// Shutdown clears everything at once, without waiting for a clock edge.
	always_ff @(posedge sys_clk or posedge primary_below_shutdown) begin
		if (primary_below_shutdown) begin
			state_q     <= ST_SHUTDOWN; // see [RULE_12] see [RULE_18]
			flg_q       <= '0;
			start_cnt_q <= '0;
			drive_q     <= 1'b0;
			drive_oe_q  <= 1'b0;
			fault_n_q   <= 1'b1;
		end else if (!nrst) begin
			state_q     <= ST_STARTUP;
			flg_q       <= '0;
			start_cnt_q <= '0;
			drive_q     <= 1'b0;
			drive_oe_q  <= 1'b0;
			fault_n_q   <= 1'b1;
		end else begin
			state_q     <= state_d;
			flg_q       <= flg_d;
			start_cnt_q <= start_cnt_d;
			drive_q     <= drive_d;
			drive_oe_q  <= drive_oe_d;
			fault_n_q   <= fault_n_d;
		end
	end

	assign fan_drive         = drive_q;
	assign fan_drive_oe      = drive_oe_q;
	assign overtemp_fault_n  = fault_n_q;
	assign overtemp_fault_oe = !fault_n_q;

	property p_shutdown_off;
		@(posedge sys_clk) disable iff (!nrst)
		primary_below_shutdown |-> !fan_drive && !fan_drive_oe && !overtemp_fault_oe;
	endproperty
	a_shutdown_off: assert property (p_shutdown_off) // see [RULE_12] see [RULE_15]
		else $error("Outputs active during shutdown");

	// The first edge after reset release still shows the reset values of the outputs.
	property p_startup_high;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		state_q == ST_STARTUP && $past(nrst) |-> fan_drive && fan_drive_oe;
	endproperty
	a_startup_high: assert property (p_startup_high) // see [RULE_05]
		else $error("Drive low during startup");

	property p_startup_len;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_STARTUP |=>
			(state_q == ST_RUN) == ($past(start_cnt_q) == STARTUP_LAST);
	endproperty
	a_startup_len: assert property (p_startup_len) // see [RULE_04]
		else $error("Startup interval not 64 periods");

	property p_sleep_entry;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_RUN && cmp.pri_below_sleep && cmp.sec_below_sleep
			&& !cmp.sleep_grounded |=> state_q == ST_SLEEP;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) // see [RULE_06]
		else $error("Sleep not entered");

	property p_one_below;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_RUN && !(cmp.pri_below_sleep && cmp.sec_below_sleep)
			|=> state_q == ST_RUN;
	endproperty
	a_one_below: assert property (p_one_below) // see [RULE_08]
		else $error("Left run with one input above sleep level");

	property p_sleep_grounded;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && cmp.sleep_grounded && state_q == ST_RUN |=> state_q != ST_SLEEP;
	endproperty
	a_sleep_grounded: assert property (p_sleep_grounded) // see [RULE_17]
		else $error("Sleep entered with sleep disabled");

	property p_wake;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_SLEEP && (cmp.pri_above_resume || cmp.sec_above_resume)
			|=> state_q == ST_STARTUP && start_cnt_q == '0 && fan_drive;
	endproperty
	a_wake: assert property (p_wake) // see [RULE_07]
		else $error("No startup after wake");

	property p_sleep_float;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		state_q == ST_SLEEP |-> !fan_drive_oe && !overtemp_fault_oe;
	endproperty
	a_sleep_float: assert property (p_sleep_float) // see [RULE_16]
		else $error("Outputs driven in sleep");

	property p_fault;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		state_q == ST_RUN |-> (overtemp_fault_n == !flg_q.pri_above_fault)
			&& (!overtemp_fault_n -> fan_drive);
	endproperty
	a_fault: assert property (p_fault) // see [RULE_09] see [RULE_10]
		else $error("Fault flag or full duty wrong");

	property p_full_duty;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		state_q == ST_RUN && flg_q.pri_above_full |-> fan_drive;
	endproperty
	a_full_duty: assert property (p_full_duty) // see [RULE_03]
		else $error("Not full duty above full level");

	property p_duty_value;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick |=> duty_frac == level_to_frac($past(primary_temp_input),
			$past(secondary_control_input));
	endproperty
	a_duty_value: assert property (p_duty_value) // see [RULE_01] see [RULE_02]
		else $error("Duty not taken from larger input");

	property p_restart;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_SHUTDOWN && cmp.pri_above_restart
			|=> state_q == ST_STARTUP && overtemp_fault_n;
	endproperty
	a_restart: assert property (p_restart) // see [RULE_14]
		else $error("No reset after restart level");

	property p_startup_step;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_STARTUP && start_cnt_q != STARTUP_LAST
			|=> state_q == ST_STARTUP && start_cnt_q == $past(start_cnt_q) + 1'b1;
	endproperty
	a_startup_step: assert property (p_startup_step) // see [RULE_04] see [RULE_05]
		else $error("Startup count did not advance by one period");

	property p_startup_hold;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		!tick && state_q == ST_STARTUP
			|=> state_q == ST_STARTUP && $stable(start_cnt_q);
	endproperty
	a_startup_hold: assert property (p_startup_hold) // see [RULE_13]
		else $error("Startup count moved between time-base ticks");

	property p_fault_release;
		@(posedge sys_clk) disable iff (!nrst || primary_below_shutdown)
		tick && state_q == ST_RUN && !cmp.pri_above_fault |=> overtemp_fault_n && !overtemp_fault_oe;
	endproperty
	a_fault_release: assert property (p_fault_release) // see [RULE_10]
		else $error("Fault flag held after primary dropped");

	property p_reset_quiet;
		@(posedge sys_clk) disable iff (primary_below_shutdown)
		!nrst |=> !fan_drive && !fan_drive_oe && overtemp_fault_n && state_q == ST_STARTUP;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) // see [RULE_05]
		else $error("Outputs active during reset");

	c_sleep:   cover property (@(posedge sys_clk) state_q == ST_RUN ##1 state_q == ST_SLEEP);
	c_wake:    cover property (@(posedge sys_clk) state_q == ST_SLEEP ##1 state_q == ST_STARTUP);
	c_fault:   cover property (@(posedge sys_clk) !overtemp_fault_n ##1 overtemp_fault_n);
	c_restart: cover property (@(posedge sys_clk) state_q == ST_SHUTDOWN ##1 state_q == ST_STARTUP);

endmodule

// ===== tb/front_end_model.sv
// Behavioural comparator front end between control levels and the sequencer.
`timescale 1ns/10ps
module front_end_model #(
	parameter int HYST = 110
) (
	input  wire fan_pkg::level_t pri_level,
	input  wire fan_pkg::level_t sec_level,
	input  wire fan_pkg::level_t slp_level,
	input  wire logic            pull_low,
	output fan_pkg::cmp_t        cmp,
	output logic                 primary_below_shutdown
);
	import fan_pkg::*;
	assign primary_below_shutdown = pull_low;
	// A level at the threshold counts as below, so a grounded threshold can still
	// present both inputs below it and the sleep disable is really exercised.
	always_comb begin
		cmp.pri_above_restart = !pull_low;
		cmp.pri_above_fault   = pri_level > FAULT_LEVEL;
		cmp.pri_above_full    = pri_level > FULL_DUTY_LEVEL;
		cmp.pri_below_sleep   = pri_level <= slp_level;
		cmp.sec_below_sleep   = sec_level <= slp_level;
		cmp.pri_above_resume  = 32'(pri_level) > 32'(slp_level) + HYST;
		cmp.sec_above_resume  = 32'(sec_level) > 32'(slp_level) + HYST;
		cmp.sleep_grounded    = slp_level == '0;
	end
endmodule

// ===== tb/fan_pwm_ctrl_tb.sv
// Self-checking bench for the fan PWM sequencer.
`timescale 1ns/10ps
module fan_pwm_ctrl_tb;
	import fan_pkg::*;
	localparam int P = 20;
	typedef struct packed {
		logic [2:0] pins;
		logic [5:0] hi;
		logic       duty;
	} note_t;
	logic   sys_clk, nrst, pull_low, below, fan_drive, fan_drive_oe;
	logic   overtemp_fault_n, overtemp_fault_oe;
	level_t pri, sec, slp;
	cmp_t   cmp;
	int     err_total, n_compared, cnt;
	note_t  notes[$];
	note_t  nt;
	event   go, done;

	front_end_model u_front_end_model (.pri_level(pri), .sec_level(sec), .slp_level(slp),
		.pull_low(pull_low), .cmp(cmp), .primary_below_shutdown(below));
	fan_pwm_ctrl #(.PERIOD_CYCLES(P)) u_fan_pwm_ctrl (.sys_clk(sys_clk), .nrst(nrst),
		.primary_below_shutdown(below), .cmp(cmp), .primary_temp_input(pri),
		.secondary_control_input(sec), .fan_drive(fan_drive), .fan_drive_oe(fan_drive_oe),
		.overtemp_fault_n(overtemp_fault_n), .overtemp_fault_oe(overtemp_fault_oe));

	task automatic cmpv(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task automatic chk(input logic [2:0] pins, input int hi);
		notes.push_back('{pins, 6'(hi), hi >= 0});
		-> go;
		@(done);
	endtask
	// Waits for the new levels to reach the duty register, then counts one period.
	task automatic run_duty(input level_t p, input level_t s, input logic fn);
		int m;
		pri = p;
		sec = s;
		m = (p > s) ? p : s;
		m = (m < 300) ? 0 : ((m > 700) ? 400 : m - 300);
		cyc(4 * P);
		chk({2'b11, fn}, m / 20);
	endtask
	// Drive must stay high through the first 60 periods of the startup kick.
	task automatic kick(input int pre);
		cyc(pre);
		repeat (60) chk(3'b111, P);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always begin
		@(go);
		nt = notes.pop_front();
		if (nt.pins[1] && !nt.duty) begin
			cmpv(fan_drive, nt.pins[2], "drive");
		end
		cmpv(fan_drive_oe, nt.pins[1], "drive enable");
		cmpv(overtemp_fault_n, nt.pins[0], "fault flag");
		cmpv(overtemp_fault_oe, !nt.pins[0], "fault enable");
		if (nt.duty) begin
			cnt = 0;
			repeat (P) begin
				if (fan_drive === 1'b1) cnt++;
				cyc(1);
			end
			cmpv(cnt, nt.hi, "high cycles");
		end
		-> done;
	end

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (1500 * P) @(posedge sys_clk);
		err_total++;
		complete_run();
	end

	initial begin
		level_t p, s;
		nrst = 1'b0;
		pull_low = 1'b0;
		pri = 10'h1F4;
		sec = 10'h136;
		slp = 10'h0C8;
		err_total = 0;
		n_compared = 0;
		void'($urandom(4372));
		cyc(5);
		chk(3'b001, -1);
		nrst = 1'b1;
		kick(1);
		$display("test power-on done");
		for (int i = 0; i < 6; i++) begin
			p = 10'(300 + 20 * ($urandom % 21));
			s = 10'(300 + 20 * ($urandom % 21));
			run_duty(p, s, 1'b1);
		end
		$display("test duty done");
		run_duty(10'h2D0, 10'h136, 1'b1);
		run_duty(10'h2EE, 10'h136, 1'b1);
		run_duty(10'h30C, 10'h136, 1'b0);
		run_duty(10'h1F4, 10'h136, 1'b1);
		run_duty(10'h096, 10'h1F4, 1'b1);
		$display("test fault done");
		pri = 10'h096;
		sec = 10'h096;
		cyc(3 * P);
		chk(3'b001, -1);
		pri = 10'h12C;
		cyc(3 * P);
		chk(3'b001, -1);
		pri = 10'h1F4;
		kick(2 * P);
		run_duty(10'h1F4, 10'h096, 1'b1);
		$display("test sleep done");
		slp = 10'h000;
		run_duty(10'h000, 10'h000, 1'b1);
		$display("test sleep disable done");
		pri = 10'h30C;
		slp = 10'h0C8;
		run_duty(10'h30C, 10'h136, 1'b0);
		cyc(7);
		pull_low = 1'b1;
		#1;
		chk(3'b001, -1);
		cyc(3 * P);
		chk(3'b001, -1);
		pri = 10'h1F4;
		pull_low = 1'b0;
		kick(2 * P);
		run_duty(10'h1F4, 10'h136, 1'b1);
		$display("test shutdown done");
		complete_run();
	end
endmodule
